/* File: design/gpiop_pkg.sv */
// Package with the register map, field widths and reset values of the port block.
package gpiop_pkg;

  // ----------------------------------------------------------------
  // Register offsets in the low I/O page.
  // ----------------------------------------------------------------
  localparam logic [15:0] GPIOP_PORT_A_DATA = 16'h0000;
  localparam logic [15:0] GPIOP_PORT_B_DATA = 16'h0001;
  localparam logic [15:0] GPIOP_PORT_C_DATA = 16'h0002;
  localparam logic [15:0] GPIOP_PORT_D_DATA = 16'h0003;
  localparam logic [15:0] GPIOP_PORT_A_DIRECTION = 16'h0004;
  localparam logic [15:0] GPIOP_PORT_B_DIRECTION = 16'h0005;
  localparam logic [15:0] GPIOP_PORT_C_DIRECTION = 16'h0006;
  localparam logic [15:0] GPIOP_PORT_D_DIRECTION = 16'h0007;
  localparam logic [15:0] GPIOP_PORT_E_DATA = 16'h0008;
  localparam logic [15:0] GPIOP_PORT_F_DATA = 16'h0009;
  localparam logic [15:0] GPIOP_PORT_G_DATA = 16'h000A;
  localparam logic [15:0] GPIOP_PORT_H_DATA = 16'h000B;
  localparam logic [15:0] GPIOP_PORT_E_DIRECTION = 16'h000C;
  localparam logic [15:0] GPIOP_PORT_F_DIRECTION = 16'h000D;
  localparam logic [15:0] GPIOP_PORT_G_DIRECTION = 16'h000E;
  localparam logic [15:0] GPIOP_PORT_H_DIRECTION = 16'h000F;

  // ----------------------------------------------------------------
  // Decoded window and port geometry.
  // ----------------------------------------------------------------
  localparam logic [15:0] GPIOP_IO_PAGE_LAST = 16'h004F;
  localparam int GPIOP_NUM_PORTS = 8;
  localparam int GPIOP_PORT_F_WIDTH = 6;
  localparam int GPIOP_PORT_GH_WIDTH = 4;
  localparam logic [7:0] GPIOP_PORT_F_MASK = 8'h3F;
  localparam logic [7:0] GPIOP_PORT_GH_MASK = 8'h0F;
  localparam logic [7:0] GPIOP_DIRECTION_RESET = 8'h00;
  localparam logic [7:0] GPIOP_READ_ZERO = 8'h00;

  // Port indices in the pin arrays.
  localparam logic [2:0] GPIOP_IDX_G = 3'h6;
  localparam logic [2:0] GPIOP_IDX_H = 3'h7;

endpackage : gpiop_pkg

/* File: design/gpiop_pin_port.sv */
// One port: data latch, direction register and pin drive for up to eight pins.
`timescale 1ns/10ps
module gpiop_pin_port
  import gpiop_pkg::*;
#(
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic data_we,
  input wire logic dir_we,
  input wire logic [7:0] wdata,
  input wire logic [7:0] pin_in,
  output logic [7:0] data_rd,
  output logic [7:0] dir_rd,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe
);

  // ----------------------------------------------------------------
  // Storage.
  // ----------------------------------------------------------------
  logic [7:0] data_q;
  logic [7:0] dir_q;
  logic [7:0] next_data_q;
  logic [7:0] next_dir_q;

  // Data latch ignores reset; direction clears; missing bits stay zero.
  always_comb begin
    next_data_q = data_q;
    next_dir_q = dir_q;
    if (data_we) begin
      next_data_q = wdata & IMPL_MASK;
    end
    if (srst) begin
      next_dir_q = GPIOP_DIRECTION_RESET;
    end else if (dir_we) begin
      next_dir_q = wdata & IMPL_MASK;
    end
  end

  // The data latch has no reset term, so its content survives any reset.
  always_ff @(posedge clk) begin
    data_q <= next_data_q;
    dir_q <= next_dir_q;
  end

  // Outputs drive the latch; inputs read the pin level.
  always_comb begin
    pin_out = data_q & IMPL_MASK;
    pin_oe = dir_q & IMPL_MASK;
    data_rd = ((dir_q & data_q) | (~dir_q & pin_in)) & IMPL_MASK;
    dir_rd = dir_q & IMPL_MASK;
  end

endmodule : gpiop_pin_port

/* File: design/gpiop_top.sv */
// Top of the general-purpose port block: address decode, read mux and eight ports.
//
// Operation
// - Ports A-D data at 0x0000-0x0003, reset-proof.
// - Ports A-D direction at 0x0004-0x0007, reset zero.
// - Port E data 0x0008, direction 0x000C.
// - Port F six bits, upper bits read zero.
// - Port G four bits, large package only.
// - Port H four bidirectional pins, reset-proof data.
// - Unimplemented access raises illegal-address reset when enabled.
// - Registers decode within 0x0000 through 0x000F.
// - Port G/H direction four bits, reset zero.
`timescale 1ns/10ps
module gpiop_top
  import gpiop_pkg::*;
#(
  parameter logic HAS_PORTS_GH = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  input wire logic illegal_addr_enable,
  input wire logic [63:0] port_pins_in,
  output logic [7:0] bus_rdata,
  output logic bus_rdata_valid,
  output logic illegal_addr_reset,
  output logic [63:0] port_pins_out,
  output logic [63:0] port_pins_oe
);

  // ----------------------------------------------------------------
  // Decode helpers.
  // ----------------------------------------------------------------

  // Returns the port index a register offset belongs to. Offsets outside
  // the port page fall to port A; every caller gates them with the page hit,
  // so the fallback never reaches a latch.
  function automatic logic [2:0] port_index(input logic [15:0] addr);
    logic [2:0] idx;
    idx = 3'h0;
    case (addr)
      GPIOP_PORT_A_DATA: idx = 3'h0;
      GPIOP_PORT_B_DATA: idx = 3'h1;
      GPIOP_PORT_C_DATA: idx = 3'h2;
      GPIOP_PORT_D_DATA: idx = 3'h3;
      GPIOP_PORT_A_DIRECTION: idx = 3'h0;
      GPIOP_PORT_B_DIRECTION: idx = 3'h1;
      GPIOP_PORT_C_DIRECTION: idx = 3'h2;
      GPIOP_PORT_D_DIRECTION: idx = 3'h3;
      GPIOP_PORT_E_DATA: idx = 3'h4;
      GPIOP_PORT_F_DATA: idx = 3'h5;
      GPIOP_PORT_G_DATA: idx = GPIOP_IDX_G;
      GPIOP_PORT_H_DATA: idx = GPIOP_IDX_H;
      GPIOP_PORT_E_DIRECTION: idx = 3'h4;
      GPIOP_PORT_F_DIRECTION: idx = 3'h5;
      GPIOP_PORT_G_DIRECTION: idx = GPIOP_IDX_G;
      GPIOP_PORT_H_DIRECTION: idx = GPIOP_IDX_H;
      default: idx = 3'h0;
    endcase
    return idx;
  endfunction : port_index

  // True when the offset selects a direction register rather than a data
  // latch. Both decodes share one table of offsets, kept in the package.
  function automatic logic is_direction(input logic [15:0] addr);
    logic dir;
    dir = 1'b0;
    case (addr)
      GPIOP_PORT_A_DIRECTION,
      GPIOP_PORT_B_DIRECTION,
      GPIOP_PORT_C_DIRECTION,
      GPIOP_PORT_D_DIRECTION,
      GPIOP_PORT_E_DIRECTION,
      GPIOP_PORT_F_DIRECTION,
      GPIOP_PORT_G_DIRECTION,
      GPIOP_PORT_H_DIRECTION: dir = 1'b1;
      default: dir = 1'b0;
    endcase
    return dir;
  endfunction : is_direction

  // ----------------------------------------------------------------
  // Access decode.
  // ----------------------------------------------------------------
  // Page hit, selected port and register, and the one-hot write strobes.
  logic in_port_page;
  logic ports_gh_access;
  logic implemented;
  logic [2:0] sel_port;
  logic sel_dir;
  logic [7:0] data_we;
  logic [7:0] dir_we;

  // Offsets 0x00-0x0F hold the port registers. Ports G and H exist only in
  // the large package; in the small one their four offsets are holes in the
  // page, which is what the illegal-address logic below keys on. The upper
  // twelve address bits must be zero, so a mirror never aliases a port.
  always_comb begin
    in_port_page = (bus_addr[15:4] == 12'h000);
    sel_port = port_index(bus_addr);
    sel_dir = is_direction(bus_addr);
    ports_gh_access = (sel_port == GPIOP_IDX_G) || (sel_port == GPIOP_IDX_H);
    implemented = in_port_page && (HAS_PORTS_GH || !ports_gh_access);
  end

  // One write strobe per port and register kind. A write to a hole or to a
  // location outside the page raises no strobe, so it can never disturb a
  // latch or a direction register.
  always_comb begin
    data_we = 8'h00;
    dir_we = 8'h00;
    if (bus_wr && implemented) begin
      if (sel_dir) begin
        dir_we[sel_port] = 1'b1;
      end else begin
        data_we[sel_port] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Port instances.
  // ----------------------------------------------------------------
  // Read-back values and unregistered pin drive of every port.
  logic [7:0] data_rd [GPIOP_NUM_PORTS];
  logic [7:0] dir_rd [GPIOP_NUM_PORTS];
  logic [63:0] pins_out_c;
  logic [63:0] pins_oe_c;

  // Ports A-E are full width, F six bits, G and H four bits. The mask is a
  // parameter of each port, so bits that a port lacks are masked to zero
  // inside it and read back as zero without any gating in the read mux. The ports
  // G and H missing from the small package are still built; the decode simply never reaches
  // them, and their pins are held undriven further down.
  for (genvar p = 0; p < GPIOP_NUM_PORTS; p++) begin : g_port
    localparam logic [7:0] MASK = (p == 5) ? GPIOP_PORT_F_MASK :
                                  (p >= 6) ? GPIOP_PORT_GH_MASK : 8'hFF;
    gpiop_pin_port #(
      .IMPL_MASK(MASK)
    ) u_port (
      .clk(clk),
      .srst(srst),
      .data_we(data_we[p]),
      .dir_we(dir_we[p]),
      .wdata(bus_wdata),
      .pin_in(port_pins_in[p*8 +: 8]),
      .data_rd(data_rd[p]),
      .dir_rd(dir_rd[p]),
      .pin_out(pins_out_c[p*8 +: 8]),
      .pin_oe(pins_oe_c[p*8 +: 8])
    );
  end

  // ----------------------------------------------------------------
  // Read mux and illegal-address detection.
  // ----------------------------------------------------------------
  // Registered bus answer and the hole detector feeding it.
  logic [7:0] next_bus_rdata;
  logic next_bus_rdata_valid;
  logic next_illegal_addr_reset;
  logic unimpl_hit;

  // Bus answer: data and valid for an implemented read, and a one-cycle flag
  // for any access that hits a hole in the port page while illegal_addr_enable is set. Locations 0x10-0x4F
  // belong to other modules and are not flagged here. Reset clears all three,
  // so no stale answer and no spurious reset request survives a reset.
  always_comb begin
    unimpl_hit = (bus_rd || bus_wr) && in_port_page && !implemented;
    next_bus_rdata = GPIOP_READ_ZERO;
    if (bus_rd && implemented) begin
      next_bus_rdata = sel_dir ? dir_rd[sel_port] : data_rd[sel_port];
    end
    next_bus_rdata_valid = bus_rd && implemented;
    next_illegal_addr_reset = unimpl_hit && illegal_addr_enable;
    if (srst) begin
      next_bus_rdata = GPIOP_READ_ZERO;
      next_bus_rdata_valid = 1'b0;
      next_illegal_addr_reset = 1'b0;
    end
  end

  // Bus answer registers. Each answer stands for exactly one cycle, so the
  // reader must take it at the edge after its strobe.
  always_ff @(posedge clk) begin
    bus_rdata <= next_bus_rdata;
    bus_rdata_valid <= next_bus_rdata_valid;
    illegal_addr_reset <= next_illegal_addr_reset;
  end

  // ----------------------------------------------------------------
  // Pin drive.
  // ----------------------------------------------------------------
  // Registered copies of the latch and direction bits of all eight ports.
  logic [63:0] next_port_pins_out;
  logic [63:0] next_port_pins_oe;

  // Pins that the small package does not bond out stay low and undriven.
  // Reset releases every pin in the same edge that clears the direction
  // registers, so no pin is driven from a stale latch for a cycle.
  always_comb begin
    next_port_pins_out = pins_out_c;
    next_port_pins_oe = pins_oe_c;
    if (!HAS_PORTS_GH) begin
      next_port_pins_out[63:48] = 16'h0000;
      next_port_pins_oe[63:48] = 16'h0000;
    end
    if (srst) begin
      next_port_pins_oe = 64'h0000000000000000;
    end
  end

  // Pin drive registers. They follow a direction or data write one cycle
  // later, which a user sees as one extra cycle before the pin turns.
  always_ff @(posedge clk) begin
    port_pins_out <= next_port_pins_out;
    port_pins_oe <= next_port_pins_oe;
  end

endmodule : gpiop_top

/* File: test/gpiop_top_asserts.sv */
// Checker for the bus answers, address decode and pin drive of the port block.
`timescale 1ns/10ps
module gpiop_top_asserts #(
  parameter logic HAS_PORTS_GH = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  input wire logic illegal_addr_enable,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rdata_valid,
  input wire logic illegal_addr_reset,
  input wire logic [63:0] port_pins_oe
);
  logic low;
  logic impl;
  // Port page offsets, and those that this package variant implements.
  assign low = bus_addr < 16'h0010;
  assign impl = low && (HAS_PORTS_GH || !(bus_addr[3] && bus_addr[1]));
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // A write of the port A direction register.
  sequence s_dir_a_wr;
    bus_wr && bus_addr == 16'h0004;
  endsequence
  a_read_answer: assert property (bus_rd && impl |=> bus_rdata_valid)
    else $error("implemented read got no answer");
  a_answer_cause: assert property (bus_rdata_valid |-> $past(bus_rd && impl))
    else $error("answer without an implemented read");
  a_illegal_raise: assert property (illegal_addr_enable && (bus_rd || bus_wr) && low && !impl
    |=> illegal_addr_reset) else $error("missing illegal-address reset");
  a_illegal_cause: assert property (illegal_addr_reset
    |-> $past(illegal_addr_enable && (bus_rd || bus_wr) && low && !impl))
    else $error("spurious illegal-address reset");
  a_f_upper_zero: assert property (bus_rd && bus_addr[15:4] == 12'h000 && bus_addr[3]
    && bus_addr[1:0] == 2'h1 |=> bus_rdata[7:6] == 2'h0)
    else $error("port F upper bits not zero");
  a_gh_upper_zero: assert property (bus_rd && impl && bus_addr[3] && bus_addr[1]
    |=> bus_rdata[7:4] == 4'h0) else $error("port G or H upper bits not zero");
  a_dir_drive: assert property (s_dir_a_wr |=> ##1 port_pins_oe[7:0] == $past(bus_wdata, 2))
    else $error("pin enables do not follow direction");
  a_reset_oe: assert property (disable iff (1'b0) srst |=> ##1 port_pins_oe == 64'h0)
    else $error("pins still driven after reset");
endmodule : gpiop_top_asserts

/* File: test/gpiop_pins_model.sv */
// Model of the outside devices wired to the port pins.
`timescale 1ns/10ps
module gpiop_pins_model (
  input wire logic [63:0] pins_out,
  input wire logic [63:0] pins_oe,
  input wire logic [63:0] ext_level,
  output logic [63:0] pins_in
);
  // A pin shows the block's drive where enabled, else the outside level.
  assign pins_in = (pins_oe & pins_out) | (~pins_oe & ext_level);
endmodule : gpiop_pins_model

/* File: test/tb.sv */
// Testbench for register access, reset, pin drive and decode of the port block.
`timescale 1ns/10ps
module tb;
  logic clk = 0, srst = 1, bus_rd = 0, bus_wr = 0, ena = 0;
  logic [15:0] bus_addr = 16'h0000, da, dd;
  logic [7:0] bus_wdata = 8'h00, bus_rdata, m, v;
  logic [63:0] ext = 64'h3CC3_965A_F00F_6699, pin_in, pin_out, pin_oe, eoe, eout, s_oe;
  logic valid, ill, s_valid, s_ill;
  int fail_count = 0, cmp_count = 0;
  always #20 clk = ~clk;
  gpiop_top dut (.clk(clk), .srst(srst), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_wdata(bus_wdata), .illegal_addr_enable(ena), .port_pins_in(pin_in),
    .bus_rdata(bus_rdata), .bus_rdata_valid(valid), .illegal_addr_reset(ill),
    .port_pins_out(pin_out), .port_pins_oe(pin_oe));
  gpiop_top #(.HAS_PORTS_GH(1'b0)) dut_small (.clk(clk), .srst(srst), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .illegal_addr_enable(ena),
    .port_pins_in(pin_in), .bus_rdata(), .bus_rdata_valid(s_valid),
    .illegal_addr_reset(s_ill), .port_pins_out(), .port_pins_oe(s_oe));
  gpiop_pins_model pins (.pins_out(pin_out), .pins_oe(pin_oe), .ext_level(ext), .pins_in(pin_in));
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1;
    @(negedge clk);
    bus_wr = 0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [8:0] e);
    @(negedge clk);
    bus_addr = a;
    bus_rd = 1;
    @(negedge clk);
    bus_rd = 0;
    check(64'({valid, bus_rdata}), 64'(e));
  endtask : rd
  task automatic conclude();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  // Cuts a hung run short.
  initial begin
    #400000;
    fail_count++;
    conclude();
  end
  // Main sequence; the stimulus also reads location 0x0010 and hits the port G/H holes of the small package.
  initial begin
    repeat (5) @(negedge clk);
    srst = 0;
    for (int i = 0; i < 8; i++) begin
      m = i < 5 ? 8'hFF : (i == 5 ? 8'h3F : 8'h0F);
      v = 8'hA5 ^ 8'(i);
      da = 16'(i < 4 ? i : i + 4);
      dd = da + 16'h0004;
      eoe[i*8+:8] = m;
      eout[i*8+:8] = v & m;
      rd(dd, 9'h100);
      rd(da, {1'b1, ext[i*8+:8] & m});
      wr(dd, 8'hFF);
      wr(da, v);
      rd(dd, {1'b1, m});
      rd(da, {1'b1, v & m});
    end
    check(pin_oe, eoe);
    check(pin_out & eoe, eout);
    check(s_oe, {16'h0000, eoe[47:0]});
    wr(16'h0004, 8'h0F);
    rd(16'h0000, {1'b1, 8'h05 | (ext[7:0] & 8'hF0)});
    srst = 1;
    repeat (2) @(negedge clk);
    srst = 0;
    check(pin_oe, 64'h0);
    wr(16'h0004, 8'hFF);
    rd(16'h0000, 9'h1A5);
    wr(16'h000F, 8'hFF);
    rd(16'h000B, 9'h102);
    rd(16'h0010, 9'h000);
    ena = 1;
    wr(16'h000A, 8'h0F);
    check(64'({s_ill, ill}), 64'h2);
    rd(16'h000E, 9'h100);
    check(64'({s_valid, s_ill}), 64'h1);
    ena = 0;
    wr(16'h000B, 8'h00);
    check(64'(s_ill), 64'h0);
    conclude();
  end
endmodule : tb
bind gpiop_top gpiop_top_asserts #(.HAS_PORTS_GH(HAS_PORTS_GH)) chk (.clk(clk), .srst(srst),
  .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
  .illegal_addr_enable(illegal_addr_enable), .bus_rdata(bus_rdata),
  .bus_rdata_valid(bus_rdata_valid), .illegal_addr_reset(illegal_addr_reset),
  .port_pins_oe(port_pins_oe));
